// *** scm_pkg.sv ***
// Constants, types and register map of the sine/cosine encoder card monitor.
// Assumes a 10 MHz clock; software reaches the registers over APB.
package scm_pkg;
	localparam int unsigned CLK_NS        = 100;
	localparam int unsigned TICK_NS       = 1_000_000;
	localparam int unsigned TICK_CYC_DEF  = TICK_NS / CLK_NS;
	localparam int unsigned BLINK_HALF_MS = 500;
	localparam int unsigned DEB_MS        = 2;
	localparam int unsigned LINK_TO_MS    = 100;
	localparam int unsigned Z_PULSE_NS    = 2_500;
	localparam int unsigned Z_PULSE_CYC   = (Z_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned EXP_MAX_DEF   = 8;

	localparam logic [11:0] ADDR_CTRL     = 12'h000;
	localparam logic [11:0] ADDR_DIV_PRI  = 12'h004;
	localparam logic [11:0] ADDR_DIV_SEC  = 12'h008;
	localparam logic [11:0] ADDR_STATUS   = 12'h00c;
	localparam logic [11:0] ADDR_IRQ_STAT = 12'h010;
	localparam logic [11:0] ADDR_IRQ_MASK = 12'h014;
	localparam logic [11:0] ADDR_ENC_CNT  = 12'h018;
	localparam logic [11:0] ADDR_REF_CNT  = 12'h01c;

	localparam int unsigned CTRL_LINK_OK  = 0;
	localparam int unsigned CTRL_SEL_SEC  = 1;
	localparam int unsigned EV_AB_LOST    = 0;
	localparam int unsigned EV_CD_LOST    = 1;
	localparam int unsigned EV_LINK_DOWN  = 2;
	localparam int unsigned EV_REF_Z      = 3;
	localparam int unsigned EV_W          = 4;

	localparam logic [1:0]  CTRL_RST      = 2'h0;
	localparam logic [3:0]  DIV_RST       = 4'h0;
	localparam logic [EV_W-1:0] MASK_RST  = 4'h0;

	typedef enum logic [1:0] {
		LINK_WAIT,
		LINK_UP,
		LINK_DOWN
	} scm_link_type;
endpackage : scm_pkg

// *** scm_top.sv ***
// Sine/cosine encoder card monitor: loss detection, indicators, link state, divided output, pulse reference.
// Assumes APB master on clk; all encoder, reference and loss-comparator inputs are asynchronous pins.
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module scm_top #(
	parameter int unsigned TICK_CYC = scm_pkg::TICK_CYC_DEF,
	parameter int unsigned EXP_MAX  = scm_pkg::EXP_MAX_DEF,
	parameter int unsigned ACC_W    = 8
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        enc_sin_a,
	input  wire logic        enc_cos_b,
	input  wire logic        enc_abs_c,
	input  wire logic        enc_abs_d,
	input  wire logic        enc_index_ref,
	input  wire logic        enc_ab_loss,
	input  wire logic        enc_cd_loss,
	input  wire logic        pulse_ref_a,
	input  wire logic        pulse_ref_b,
	input  wire logic        pulse_ref_z,
	output logic             div_out_a,
	output logic             div_out_b,
	output logic             div_out_z,
	output logic             disconnect_indicator,
	output logic             link_state_indicator,
	output logic             irq
);
	import scm_pkg::*;

	localparam int unsigned TW = $clog2(TICK_CYC + 1);
	// Returns {step, up} for a change of a quadrature pair
	function automatic logic [1:0] quad_step(input logic [1:0] prev, input logic [1:0] cur);
		unique case ({prev, cur})
			4'b0010, 4'b1011, 4'b1101, 4'b0100: quad_step = 2'b11;
			4'b0001, 4'b0111, 4'b1110, 4'b1000: quad_step = 2'b10;
			default:                            quad_step = 2'b00;
		endcase
	endfunction : quad_step
	logic [9:0]      raw;
	logic [9:0]      s1_q;
	logic [9:0]      s2_q;
	logic [9:0]      s3_q;
	logic [TW-1:0]   tick_cnt_q;
	logic            tick_q;
	logic [1:0]      lost_q;
	logic [7:0]      deb_cnt_q [2];
	logic [9:0]      half_cnt_q;
	logic            blink_q;
	scm_link_type    link_q;
	logic [7:0]      hb_cnt_q;
	logic            link_enter_up;
	logic            link_enter_down;
	logic [1:0]      ctrl_q;
	logic [3:0]      exp_pri_q;
	logic [3:0]      exp_sec_q;
	logic [3:0]      exp_cur;
	logic [EV_W-1:0] irq_stat_q;
	logic [EV_W-1:0] irq_mask_q;
	logic [EV_W-1:0] ev;
	logic [1:0]      lost_d1_q;
	logic [31:0]     enc_cnt_q;
	logic [31:0]     ref_cnt_q;
	logic [ACC_W-1:0] acc_q;
	logic [ACC_W-1:0] z_cnt_q;
	logic [ACC_W-1:0] div_mask;
	logic [7:0]      z_len_q;
	logic [1:0]      enc_step;
	logic [1:0]      ref_step;
	logic            idx_rise;
	logic            ref_z_rise;
	logic            acc_wr;
	logic            wr_ctrl;
	logic [31:0]     rdata_d;
	logic            hit_d;
	logic [3:0]      wexp;
	// Two-flop synchronisers, third stage only for edge detection
	assign raw = {enc_ab_loss, enc_cd_loss, pulse_ref_z, pulse_ref_b, pulse_ref_a,
		enc_index_ref, enc_abs_d, enc_abs_c, enc_cos_b, enc_sin_a};
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_q <= 10'h000;
			s2_q <= 10'h000;
			s3_q <= 10'h000;
		end else begin
			s1_q <= raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	// The function takes pairs as {A, B}; the pin vector holds B above A
	assign enc_step   = quad_step({s3_q[0], s3_q[1]}, {s2_q[0], s2_q[1]});
	assign ref_step   = quad_step({s3_q[5], s3_q[6]}, {s2_q[5], s2_q[6]});
	assign idx_rise   = s2_q[4] & ~s3_q[4];
	assign ref_z_rise = s2_q[7] & ~s3_q[7];
	// Millisecond enable
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tick_cnt_q <= '0;
			tick_q     <= 1'b0;
		end else if (tick_cnt_q == TW'(TICK_CYC - 1)) begin
			tick_cnt_q <= '0;
			tick_q     <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + TW'(1);
			tick_q     <= 1'b0;
		end
	end
	// Loss debounce: bit 0 A/B pair, bit 1 C/D pair
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lost_q       <= 2'h0;
			deb_cnt_q[0] <= 8'h00;
			deb_cnt_q[1] <= 8'h00;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (s2_q[9 - i] == lost_q[i]) begin
					deb_cnt_q[i] <= 8'h00;
				end else if (tick_q) begin
					if (deb_cnt_q[i] == 8'(DEB_MS - 1)) begin
						lost_q[i]    <= s2_q[9 - i];
						deb_cnt_q[i] <= 8'h00;
					end else begin
						deb_cnt_q[i] <= deb_cnt_q[i] + 8'h01;
					end
				end
			end
		end
	end
	// Half-second blink phase, restarted lit on link up
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			half_cnt_q <= 10'h000;
			blink_q    <= 1'b1;
		end else if (link_enter_up) begin
			half_cnt_q <= 10'h000;
			blink_q    <= 1'b1;
		end else if (tick_q) begin
			if (half_cnt_q == 10'(BLINK_HALF_MS - 1)) begin
				half_cnt_q <= 10'h000;
				blink_q    <= ~blink_q;
			end else begin
				half_cnt_q <= half_cnt_q + 10'h001;
			end
		end
	end
	// Link with the control board: it writes CTRL as heartbeat
	assign wr_ctrl = psel && penable && pready && pwrite && paddr == ADDR_CTRL;
	assign link_enter_up = wr_ctrl && pwdata[CTRL_LINK_OK] && link_q != LINK_UP;
	assign link_enter_down = link_q == LINK_UP &&
		((wr_ctrl && !pwdata[CTRL_LINK_OK]) || (tick_q && hb_cnt_q == 8'(LINK_TO_MS - 1)));
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			link_q   <= LINK_WAIT;
			hb_cnt_q <= 8'h00;
		end else begin
			if (wr_ctrl)
				hb_cnt_q <= 8'h00;
			else if (tick_q && link_q == LINK_UP)
				hb_cnt_q <= hb_cnt_q + 8'h01;
			if (link_enter_up)
				link_q <= LINK_UP;
			else if (link_enter_down)
				link_q <= LINK_DOWN;
		end
	end
	// Indicators
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			disconnect_indicator <= 1'b1;
			link_state_indicator <= 1'b1;
		end else begin
			if (lost_q[0])
				disconnect_indicator <= 1'b0;
			else if (lost_q[1])
				disconnect_indicator <= blink_q;
			else
				disconnect_indicator <= 1'b1;
			unique case (link_q)
				LINK_WAIT: link_state_indicator <= 1'b1;
				LINK_UP:   link_state_indicator <= blink_q;
				LINK_DOWN: link_state_indicator <= 1'b0;
				default:   link_state_indicator <= 1'b0;
			endcase
		end
	end
	// Divider by 2**N; one output quadrature step per 2**N input steps
	assign exp_cur  = ctrl_q[CTRL_SEL_SEC] ? exp_sec_q : exp_pri_q;
	assign div_mask = ACC_W'((9'h001 << exp_cur) - 9'h001);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			acc_q     <= '0;
			div_out_a <= 1'b0;
			div_out_b <= 1'b0;
		end else if (enc_step[1]) begin
			if (enc_step[0]) begin
				if (acc_q >= div_mask) begin
					acc_q     <= '0;
					div_out_a <= ~div_out_b;
					div_out_b <= div_out_a;
				end else begin
					acc_q <= acc_q + ACC_W'(1);
				end
			end else if (acc_q == '0) begin
				acc_q     <= div_mask;
				div_out_a <= div_out_b;
				div_out_b <= ~div_out_a;
			end else begin
				acc_q <= acc_q - ACC_W'(1);
			end
		end
	end
	// Divided index: fixed-width pulse keeps Z under 400 kHz
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			z_cnt_q   <= '0;
			z_len_q   <= 8'h00;
			div_out_z <= 1'b0;
		end else begin
			if (idx_rise && z_cnt_q >= div_mask) begin
				z_cnt_q   <= '0;
				z_len_q   <= 8'(Z_PULSE_CYC - 1);
				div_out_z <= 1'b1;
			end else begin
				if (idx_rise)
					z_cnt_q <= z_cnt_q + ACC_W'(1);
				if (z_len_q != 8'h00)
					z_len_q <= z_len_q - 8'h01;
				else
					div_out_z <= 1'b0;
			end
		end
	end
	// Position counters of encoder and pulse reference
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			enc_cnt_q <= 32'h0000_0000;
			ref_cnt_q <= 32'h0000_0000;
		end else begin
			if (enc_step[1])
				enc_cnt_q <= enc_step[0] ? enc_cnt_q + 32'h1 : enc_cnt_q - 32'h1;
			if (ref_step[1])
				ref_cnt_q <= ref_step[0] ? ref_cnt_q + 32'h1 : ref_cnt_q - 32'h1;
		end
	end
	// APB: one wait state, data and answer from flip-flops
	always_comb begin
		hit_d   = 1'b1;
		rdata_d = 32'h0000_0000;
		unique case (paddr)
			ADDR_CTRL:     rdata_d = {30'h0, ctrl_q};
			ADDR_DIV_PRI:  rdata_d = {28'h0, exp_pri_q};
			ADDR_DIV_SEC:  rdata_d = {28'h0, exp_sec_q};
			ADDR_STATUS:   rdata_d = {26'h0, s2_q[3:2], link_q, lost_q};
			ADDR_IRQ_STAT: rdata_d = {28'h0, irq_stat_q};
			ADDR_IRQ_MASK: rdata_d = {28'h0, irq_mask_q};
			ADDR_ENC_CNT:  rdata_d = enc_cnt_q;
			ADDR_REF_CNT:  rdata_d = ref_cnt_q;
			default:       hit_d   = 1'b0;
		endcase
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (psel && penable && !pready) begin
			pready  <= 1'b1;
			pslverr <= ~hit_d;
			prdata  <= pwrite ? 32'h0000_0000 : rdata_d;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end
	assign acc_wr = psel && penable && pready && pwrite;
	assign wexp   = pwdata[7:0] > 8'(EXP_MAX) ? 4'(EXP_MAX) : pwdata[3:0];
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_q     <= CTRL_RST;
			exp_pri_q  <= DIV_RST;
			exp_sec_q  <= DIV_RST;
			irq_mask_q <= MASK_RST;
		end else if (acc_wr) begin
			if (paddr == ADDR_CTRL)
				ctrl_q <= pwdata[1:0];
			if (paddr == ADDR_DIV_PRI)
				exp_pri_q <= wexp;
			if (paddr == ADDR_DIV_SEC)
				exp_sec_q <= wexp;
			if (paddr == ADDR_IRQ_MASK)
				irq_mask_q <= pwdata[EV_W-1:0];
		end
	end
	// Sticky events, write one to clear, a new event wins
	assign ev = {ref_z_rise, link_enter_down, lost_q & ~lost_d1_q};
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lost_d1_q  <= 2'h0;
			irq_stat_q <= '0;
			irq        <= 1'b0;
		end else begin
			lost_d1_q <= lost_q;
			if (acc_wr && paddr == ADDR_IRQ_STAT)
				irq_stat_q <= (irq_stat_q & ~pwdata[EV_W-1:0]) | ev;
			else
				irq_stat_q <= irq_stat_q | ev;
			irq <= |(irq_stat_q & irq_mask_q);
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_ab_dark;
		lost_q[0] |=> !disconnect_indicator;
	endproperty
	a_ab_dark: assert property (p_ab_dark) else $error("indicator lit with A/B lost");
	property p_cd_blink;
		(!lost_q[0] && lost_q[1]) |=> disconnect_indicator == $past(blink_q);
	endproperty
	a_cd_blink: assert property (p_cd_blink) else $error("indicator not blinking with C/D lost");
	property p_ok_lit;
		lost_q == 2'h0 |=> disconnect_indicator;
	endproperty
	a_ok_lit: assert property (p_ok_lit) else $error("indicator dark with channels normal");
	property p_wait_lit;
		link_q == LINK_WAIT |=> link_state_indicator;
	endproperty
	a_wait_lit: assert property (p_wait_lit) else $error("link indicator dark while connecting");
	property p_blink_half;
		($changed(blink_q) && !$past(link_enter_up)) |-> ($past(tick_q) && $past(half_cnt_q) == 10'(BLINK_HALF_MS - 1));
	endproperty
	a_blink_half: assert property (p_blink_half) else $error("blink toggled off the half period");
	property p_down_dark;
		link_q == LINK_DOWN |=> !link_state_indicator;
	endproperty
	a_down_dark: assert property (p_down_dark) else $error("link indicator lit after loss");
	property p_div_cause;
		$changed({div_out_a, div_out_b}) |-> $past(enc_step[1]) && $past(acc_q == '0 || acc_q >= div_mask);
	endproperty
	a_div_cause: assert property (p_div_cause) else $error("divided output stepped without wrap");
	property p_quad;
		$changed({div_out_a, div_out_b}) |-> $onehot({div_out_a ^ $past(div_out_a), div_out_b ^ $past(div_out_b)});
	endproperty
	a_quad: assert property (p_quad) else $error("divided outputs changed together");
	property p_ref_up;
		ref_step == 2'b11 |=> ref_cnt_q == $past(ref_cnt_q) + 32'h1;
	endproperty
	a_ref_up: assert property (p_ref_up) else $error("reference count missed a step");
	property p_deb_tick;
		$changed(lost_q) |-> $past(tick_q);
	endproperty
	a_deb_tick: assert property (p_deb_tick) else $error("loss flag changed off a tick");
	property p_apb_wait;
		(psel && penable && !pready) |=> pready ##1 !pready;
	endproperty
	a_apb_wait: assert property (p_apb_wait) else $error("APB answer not one wait state");
	c_cd_lost: cover property (!lost_q[0] && lost_q[1]);
	c_link_up: cover property (link_q == LINK_UP ##1 link_q == LINK_DOWN);
	c_div_z:   cover property ($rose(div_out_z));
endmodule : scm_top
`default_nettype wire

// *** scm_enc_model.sv ***
// Model of the encoder, its loss comparators and the pulse reference source.
// Assumes it shares the card clock; every step is held 4 cycles.
`timescale 1ns/1ps
`default_nettype none
module scm_enc_model (
	input  wire logic clk,
	output logic      enc_sin_a,
	output logic      enc_cos_b,
	output logic      enc_abs_c,
	output logic      enc_abs_d,
	output logic      enc_index_ref,
	output logic      enc_ab_loss,
	output logic      enc_cd_loss,
	output logic      pulse_ref_a,
	output logic      pulse_ref_b,
	output logic      pulse_ref_z
);
	logic [1:0] ph;
	logic [1:0] rp;
	initial begin
		{enc_sin_a, enc_cos_b, pulse_ref_a, pulse_ref_b} = 4'h0;
		{enc_ab_loss, enc_cd_loss, enc_abs_c, enc_abs_d, enc_index_ref, pulse_ref_z} = 6'h00;
		ph = 2'h0;
		rp = 2'h0;
	end
	// Forward order of the pair is 00, 10, 11, 01; index and reference Z mark phase zero
	task step(input logic up, input logic rf, input int n);
		repeat (n) begin
			@(posedge clk);
			if (rf) begin
				rp = up ? rp + 2'h1 : rp - 2'h1;
				{pulse_ref_a, pulse_ref_b} <= {rp[1] ^ rp[0], rp[1]};
				pulse_ref_z <= (rp == 2'h0);
			end else begin
				ph = up ? ph + 2'h1 : ph - 2'h1;
				{enc_sin_a, enc_cos_b} <= {ph[1] ^ ph[0], ph[1]};
				enc_index_ref <= (ph == 2'h0);
			end
			repeat (3) @(posedge clk);
		end
	endtask : step
	task set_lv(input logic [3:0] v);
		{enc_ab_loss, enc_cd_loss, enc_abs_c, enc_abs_d} <= v;
	endtask : set_lv
endmodule : scm_enc_model
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench of the encoder card monitor: APB tasks and scenario sequence.
// Assumes the card's tick shortened to 10 cycles; the model drives the encoder pins.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import scm_pkg::*;
	localparam int unsigned TK   = 10;
	localparam int unsigned HALF = BLINK_HALF_MS * TK;
	logic        clk, rst, psel, penable, pwrite, pready, pslverr, irq, se;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        enc_sin_a, enc_cos_b, enc_abs_c, enc_abs_d, enc_index_ref, enc_ab_loss, enc_cd_loss;
	logic        pulse_ref_a, pulse_ref_b, pulse_ref_z, div_out_a, div_out_b, div_out_z;
	logic        disconnect_indicator, link_state_indicator, li_p, di_p;
	int          miscompares, total_checks, cyc, li_t, hi_len, lo_len, dtog, z_run, z_w;

	scm_top #(.TICK_CYC(TK)) dut_u (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .enc_sin_a, .enc_cos_b, .enc_abs_c, .enc_abs_d, .enc_index_ref, .enc_ab_loss, .enc_cd_loss,
		.pulse_ref_a, .pulse_ref_b, .pulse_ref_z, .div_out_a, .div_out_b, .div_out_z, .disconnect_indicator,
		.link_state_indicator, .irq);
	scm_enc_model enc_u (.clk, .enc_sin_a, .enc_cos_b, .enc_abs_c, .enc_abs_d, .enc_index_ref, .enc_ab_loss,
		.enc_cd_loss, .pulse_ref_a, .pulse_ref_b, .pulse_ref_z);

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task finish_test;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : finish_test

	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(nm, rd, exp);
	endtask : rdchk

	// Heartbeat writes keep the link up while time passes
	task hb(input int k);
		repeat (k) begin
			repeat (500) @(posedge clk);
			apb(1'b1, ADDR_CTRL, 32'h3);
		end
	endtask : hb

	// Run lengths of the link indicator and toggles of the disconnect indicator
	always @(posedge clk) begin
		cyc++;
		if (link_state_indicator !== li_p) begin
			if (li_p)
				hi_len = cyc - li_t;
			else
				lo_len = cyc - li_t;
			li_t = cyc;
		end
		li_p = link_state_indicator;
		if (disconnect_indicator !== di_p)
			dtog++;
		di_p = disconnect_indicator;
		if (div_out_z === 1'b1)
			z_run++;
		else if (z_run != 0) begin
			z_w = z_run;
			z_run = 0;
		end
		if (cyc > 60000) begin
			miscompares++;
			finish_test();
		end
	end

	initial begin
		{rst, li_p, di_p} = 3'b111;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{miscompares, total_checks, cyc, li_t, hi_len, lo_len, dtog, z_run, z_w} = '0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("disc_ind", disconnect_indicator, 1);
		rdchk("ctrl", ADDR_CTRL, CTRL_RST);
		rdchk("mask", ADDR_IRQ_MASK, MASK_RST);
		rdchk("status", ADDR_STATUS, 32'h0);
		apb(1'b0, 12'h020, 32'h0);
		chk("slverr", se, 1);
		repeat (300) @(posedge clk);
		chk("link_ind", link_state_indicator, 1);
		$display("test reset done");

		apb(1'b1, ADDR_DIV_PRI, 32'h2);
		enc_u.step(1'b1, 1'b0, 4);
		repeat (3) @(posedge clk);
		chk("div_ab", {div_out_a, div_out_b}, 2'b10);
		enc_u.step(1'b1, 1'b0, 3);
		enc_u.step(1'b0, 1'b0, 3);
		repeat (3) @(posedge clk);
		chk("div_ab", {div_out_a, div_out_b}, 2'b10);
		enc_u.step(1'b0, 1'b0, 1);
		repeat (3) @(posedge clk);
		chk("div_ab", {div_out_a, div_out_b}, 2'b00);
		rdchk("enc_cnt", ADDR_ENC_CNT, 32'h3);
		apb(1'b1, ADDR_DIV_PRI, 32'hf);
		rdchk("div_pri", ADDR_DIV_PRI, 32'h8);
		$display("test divider done");

		apb(1'b1, ADDR_DIV_SEC, 32'h0);
		apb(1'b1, ADDR_CTRL, 32'h3);
		chk("link_ind", link_state_indicator, 1);
		enc_u.step(1'b1, 1'b0, 1);
		repeat (3) @(posedge clk);
		chk("div_ab", {div_out_a, div_out_b}, 2'b10);
		repeat (30) @(posedge clk);
		chk("z_width", z_w, Z_PULSE_CYC);
		$display("test index done");

		enc_u.set_lv(4'h4);
		dtog = 0;
		hb(32);
		chk("hi_len", hi_len, HALF);
		chk("lo_len", lo_len, HALF);
		chk("disc_blink", dtog >= 2, 1);
		rdchk("status", ADDR_STATUS, 32'h6);
		apb(1'b1, ADDR_IRQ_MASK, 32'h2);
		repeat (2) @(posedge clk);
		chk("irq", irq, 1);
		apb(1'b1, ADDR_IRQ_STAT, 32'h2);
		repeat (2) @(posedge clk);
		chk("irq", irq, 0);
		enc_u.set_lv(4'h8);
		hb(1);
		chk("disc_ind", disconnect_indicator, 0);
		dtog = 0;
		hb(12);
		chk("disc_tog", dtog, 0);
		rdchk("irq_stat", ADDR_IRQ_STAT, 32'h1);
		enc_u.set_lv(4'h0);
		hb(1);
		chk("disc_ind", disconnect_indicator, 1);
		dtog = 0;
		hb(12);
		chk("disc_tog", dtog, 0);
		$display("test loss done");

		apb(1'b1, ADDR_IRQ_MASK, 32'h4);
		repeat (LINK_TO_MS * TK - 3 * TK) @(posedge clk);
		rdchk("status", ADDR_STATUS, 32'h4);
		repeat (5 * TK) @(posedge clk);
		chk("link_ind", link_state_indicator, 0);
		chk("irq", irq, 1);
		rdchk("status", ADDR_STATUS, 32'h8);
		enc_u.set_lv(4'h3);
		repeat (5) @(posedge clk);
		rdchk("status", ADDR_STATUS, 32'h38);
		apb(1'b1, ADDR_IRQ_STAT, 32'hf);
		$display("test link done");

		enc_u.step(1'b1, 1'b1, 5);
		repeat (10) @(posedge clk);
		rdchk("ref_cnt", ADDR_REF_CNT, 32'h5);
		rdchk("irq_stat", ADDR_IRQ_STAT, 32'h8);
		$display("test reference done");
		finish_test();
	end
endmodule : testbench
`default_nettype wire
